// ===== verilog/supervisor_reset_watchdog.sv
// Reset supervisor: supply monitor, manual reset and watchdog driving a reset pair.
// Operation
// R1 - Timeout select low, open, high gives 150, 600, 1200 ms watchdog period.
// R2 - Reset active on low supply, manual reset, power-up, watchdog expiry.
// R3 - Active-low reset is always the exact complement of active-high reset.
// R4 - Tolerance select low picks tighter trip, high picks looser trip.
// R5 - After supply recovers, reset stays active for the 600 ms reset period.
// R6 - Manual low for 20 ms asserts reset; held 250 ms or more after release.
// R7 - Manual reset input is debounced and reads high when undriven.
// R8 - Reset becomes active within 20 ms of manual input stably low.
// R9 - Reset asserts within 8 us of supply falling below trip.
// R10 - Reset held continuously while supply is below trip during power-down.
// R11 - Watchdog cannot be disabled; every unstrobed timeout resets.
// R12 - Host strobes faster than the minimum selected watchdog timeout.
// R13 - Watchdog starts after reset release; each strobe falling edge restarts it.
// R14 - After a watchdog reset ends, watchdog timing restarts from zero.
// R15 - All timing comes from one timebase with parameterised cycle counts.
// R16 - Overlapping causes keep reset until last clears plus full period.
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_watchdog
   import supervisor_pkg::*;
#(
   parameter int unsigned WDT_SHORT = WDT_SHORT_CYC,
   parameter int unsigned WDT_MID = WDT_MID_CYC,
   parameter int unsigned WDT_LONG = WDT_LONG_CYC,
   parameter int unsigned RESET_PERIOD = RESET_PERIOD_CYC,
   parameter int unsigned DEBOUNCE = DEBOUNCE_CYC
) (
   // Clock and power-on reset
   input wire logic clk_sys,
   input wire logic rst,
   // Supply comparators and selects
   input wire supply_status_type supply_status,
   input wire logic trip_tolerance_select,
   input wire timeout_select_type timeout_select,
   // Host pins
   input wire logic manual_reset_n,
   input wire logic watchdog_strobe_n,
   output reset_out_type reset_out
);
   typedef enum logic [1:0] {
      ST_RESET = 2'b01,
      ST_RUN = 2'b10
   } state_type;

   state_type state_q;
   supply_status_type sup1_q, sup2_q;
   logic tol1_q, tol2_q;
   logic stb1_q, stb2_q, stb3_q;
   logic [1:0] tsel1_q, tsel2_q;
   logic manual_low;
   logic supply_low;
   logic strobe_fall;
   logic wdt_expire;
   logic cause_active;
   logic [TIMER_WIDTH-1:0] hold_q;
   logic [TIMER_WIDTH-1:0] wdt_q;
   logic [TIMER_WIDTH-1:0] wdt_limit;
   logic reset_q;
   logic [TIMER_WIDTH-1:0] quiet_q;

   // Debounce also covers the pull-up: an undriven pin is modelled high by the pad. [R7]
   pin_debouncer #(.STABLE_CYC(DEBOUNCE)) u_manual (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_n(manual_reset_n),
      .stable_low(manual_low)
   );

   // Comparators and strap cross together; choosing before the flops would read an unsynchronised pin.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sup1_q <= '1;
         sup2_q <= '1;
         tol1_q <= TOL_TIGHT;
         tol2_q <= TOL_TIGHT;
      end else begin
         sup1_q <= supply_status;
         sup2_q <= sup1_q;
         tol1_q <= trip_tolerance_select;
         tol2_q <= tol1_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stb1_q <= 1'h1;
         stb2_q <= 1'h1;
         stb3_q <= 1'h1;
      end else begin
         stb1_q <= watchdog_strobe_n;
         stb2_q <= stb1_q;
         stb3_q <= stb2_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tsel1_q <= TSEL_LOW;
         tsel2_q <= TSEL_LOW;
      end else begin
         tsel1_q <= timeout_select;
         tsel2_q <= tsel1_q;
      end
   end

   // Tolerance select picks which comparator trips. [R4]
   assign supply_low = (tol2_q == TOL_TIGHT) ? sup2_q.below_tight : sup2_q.below_loose;
   assign strobe_fall = stb3_q & ~stb2_q;

   // Select timeout period; an illegal code falls back to the shortest. [R1] [R15]
   always_comb begin
      unique case (tsel2_q)
         TSEL_OPEN: wdt_limit = TIMER_WIDTH'(WDT_MID);
         TSEL_HIGH: wdt_limit = TIMER_WIDTH'(WDT_LONG);
         default: wdt_limit = TIMER_WIDTH'(WDT_SHORT);
      endcase
   end

   assign wdt_expire = (state_q == ST_RUN) && (wdt_q >= wdt_limit - TIMER_WIDTH'(1));
   // Supply-low enters reset directly, well inside the 8 us bound. [R2] [R9] [R8]
   assign cause_active = supply_low | manual_low;

   // Reset sequencer; the power-on reset starts it in the reset state. [R2] [R16]
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= ST_RESET;
         hold_q <= '0;
      end else begin
         unique case (state_q)
            ST_RESET: begin
               // Any live cause reloads the hold so the period counts from the last release. [R5] [R6] [R10] [R16]
               if (cause_active) begin
                  hold_q <= '0;
               end else if (hold_q >= TIMER_WIDTH'(RESET_PERIOD - 1)) begin
                  state_q <= ST_RUN;
                  hold_q <= '0;
               end else begin
                  hold_q <= hold_q + TIMER_WIDTH'(1);
               end
            end
            ST_RUN: begin
               // No enable exists: expiry always re-enters reset. [R11]
               if (cause_active || wdt_expire) begin
                  state_q <= ST_RESET;
                  hold_q <= '0;
               end
            end
         endcase
      end
   end

   // Watchdog counts only while released and clears on every strobe falling edge. [R13] [R14]
   always_ff @(posedge clk_sys) begin
      if (rst || state_q != ST_RUN || strobe_fall || wdt_expire) begin
         wdt_q <= '0;
      end else begin
         wdt_q <= wdt_q + TIMER_WIDTH'(1);
      end
   end

   // Output is registered and cause-driven, so a live cause takes effect in one edge.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reset_q <= 1'h1;
      end else begin
         reset_q <= (state_q == ST_RESET) | cause_active | wdt_expire;
      end
   end

   // Counts how long reset has stood with no live cause; only the period checks read it.
   always_ff @(posedge clk_sys) begin
      if (rst || cause_active || !reset_q) begin
         quiet_q <= '0;
      end else if (quiet_q != '1) begin
         quiet_q <= quiet_q + TIMER_WIDTH'(1);
      end
   end

   assign reset_out.reset = reset_q;
   assign reset_out.reset_n = ~reset_q; // [R3]

   a_pair_complement: assert property (@(posedge clk_sys) disable iff (rst) reset_out.reset_n == ~reset_out.reset) // [R3]
      else $error("reset pair not complementary");
   a_supply_fast: assert property (@(posedge clk_sys) disable iff (rst) supply_low |=> reset_out.reset) // [R9]
      else $error("supply low did not assert reset");
   default clocking cb_sys @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Antecedents used by the checks below; s_wdt_counting is a single cycle.
   sequence s_supply_low_held;
      supply_low ##1 supply_low;
   endsequence
   sequence s_manual_release;
      manual_low ##1 !manual_low;
   endsequence
   sequence s_wdt_counting;
      (state_q == ST_RUN) && !strobe_fall && !wdt_expire;
   endsequence
   a_supply_hold: assert property (s_supply_low_held |-> reset_out.reset) // [R10]
      else $error("reset dropped during supply low");
   a_manual_release: assert property (s_manual_release |-> reset_out.reset [*8]) // [R6]
      else $error("reset released too soon after manual input");
   a_power_up: assert property ($fell(rst) |-> reset_out.reset [*8]) // [R2]
      else $error("reset not held after power-up");
   a_cause_reset: assert property (cause_active |=> reset_out.reset) // [R2]
      else $error("live cause without reset");
   a_manual_assert: assert property (@(posedge clk_sys) disable iff (rst) manual_low |=> reset_out.reset) // [R8]
      else $error("manual low did not assert reset");
   a_release_gap: assert property (@(posedge clk_sys) disable iff (rst) $fell(cause_active) |-> reset_out.reset [*8]) // [R5]
      else $error("reset released too soon after cause");
   a_wdt_reset: assert property (@(posedge clk_sys) disable iff (rst) wdt_expire |=> reset_out.reset && state_q == ST_RESET) // [R11]
      else $error("watchdog expiry without reset");
   a_wdt_idle: assert property (@(posedge clk_sys) disable iff (rst) state_q == ST_RESET |=> wdt_q == '0) // [R14]
      else $error("watchdog counted during reset");
   a_strobe_restart: assert property (@(posedge clk_sys) disable iff (rst) strobe_fall |=> wdt_q == '0) // [R13]
      else $error("strobe did not restart watchdog");
   a_release_count: assert property ($fell(reset_q) |-> $past(hold_q, 2) == TIMER_WIDTH'(RESET_PERIOD - 1)) // [R16]
      else $error("release without full period");
   a_period_full: assert property ($fell(reset_q) |-> $past(quiet_q) >= TIMER_WIDTH'(RESET_PERIOD)) // [R5] [R16]
      else $error("reset shorter than the reset period");
   a_wdt_step: assert property (s_wdt_counting |=> wdt_q == $past(wdt_q) + 1'h1) // [R15]
      else $error("watchdog count did not advance");
   a_wdt_limit: assert property (state_q == ST_RUN && $stable(tsel2_q) |-> wdt_q < wdt_limit) // [R1]
      else $error("watchdog count passed its limit");
endmodule // supervisor_reset_watchdog
`default_nettype wire

// ===== verilog/supervisor_pkg.sv
// Package with timing constants, select codes and carrier types of the reset supervisor.
package supervisor_pkg;
   // Clock period of clk_sys in nanoseconds (10 MHz).
   localparam int unsigned CLK_PERIOD_NS = 100;
   // Nominal durations in milliseconds; the supply-fail delay is in microseconds.
   localparam int unsigned WDT_SHORT_MS = 150;
   localparam int unsigned WDT_MID_MS = 600;
   localparam int unsigned WDT_LONG_MS = 1200;
   localparam int unsigned RESET_PERIOD_MS = 600;
   localparam int unsigned MANUAL_RESET_ASSERT_DELAY_MS = 20;
   localparam int unsigned SUPPLY_FAIL_ASSERT_DELAY_US = 8;
   localparam int unsigned NS_PER_MS = 1000000;
   localparam int unsigned NS_PER_US = 1000;
   // Derived cycle counts; nominal times are exact multiples of the period.
   localparam int unsigned WDT_SHORT_CYC = WDT_SHORT_MS * (NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned WDT_MID_CYC = WDT_MID_MS * (NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned WDT_LONG_CYC = WDT_LONG_MS * (NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned RESET_PERIOD_CYC = RESET_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned DEBOUNCE_CYC = MANUAL_RESET_ASSERT_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
   // Longest time, rounded down.
   localparam int unsigned SUPPLY_FAIL_ASSERT_CYC = (SUPPLY_FAIL_ASSERT_DELAY_US * NS_PER_US) / CLK_PERIOD_NS;
   localparam int unsigned TIMER_WIDTH = 24;
   // Three-level timeout select as seen through a tri-level detector.
   typedef enum logic [1:0] {
      TSEL_LOW = 2'h0,
      TSEL_OPEN = 2'h1,
      TSEL_HIGH = 2'h2
   } timeout_select_type;
   // Trip tolerance: low picks the tighter threshold.
   localparam logic TOL_TIGHT = 1'h0;
   localparam logic TOL_LOOSE = 1'h1;
   // Supply status carried as a group.
   typedef struct packed {
      logic below_tight;
      logic below_loose;
   } supply_status_type;
   // Reset pair to the host.
   typedef struct packed {
      logic reset;
      logic reset_n;
   } reset_out_type;
endpackage : supervisor_pkg

// ===== verilog/pin_debouncer.sv
// Synchroniser and debouncer for an active-low pin.
`timescale 1ns/1ps
`default_nettype none
module pin_debouncer
   import supervisor_pkg::*;
#(
   parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Pin and result
   input wire logic pin_n,
   output logic stable_low
);
   logic sync1_q;
   logic sync2_q;
   logic [TIMER_WIDTH-1:0] cnt_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_q <= 1'h1;
         sync2_q <= 1'h1;
      end else begin
         sync1_q <= pin_n;
         sync2_q <= sync1_q;
      end
   end

   // Bounce restarts the count, so only a continuous low is accepted.
   always_ff @(posedge clk_sys) begin
      if (rst || sync2_q) begin
         cnt_q <= '0;
         stable_low <= 1'h0;
      end else if (cnt_q >= TIMER_WIDTH'(STABLE_CYC - 1)) begin
         stable_low <= 1'h1;
      end else begin
         cnt_q <= cnt_q + TIMER_WIDTH'(1);
      end
   end
endmodule // pin_debouncer
`default_nettype wire

// ===== bench/host_model.sv
// Host model that strobes the watchdog at a fixed interval.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
   parameter int unsigned INTERVAL = 20
) (
   // Clock and control
   input wire logic clk_sys,
   input wire logic strobe_en,
   // Strobe pin
   output var logic watchdog_strobe_n
);
   int unsigned count_q = 0;
   initial watchdog_strobe_n = 1'h1;
   // Pulses stay two cycles wide and come well inside the shortest timeout.
   always @(negedge clk_sys) begin
      count_q <= (!strobe_en || count_q == INTERVAL - 1) ? 0 : count_q + 1;
      watchdog_strobe_n <= !(strobe_en && count_q < 2);
   end
endmodule // host_model
`default_nettype wire

// ===== bench/supervisor_reset_watchdog_test.sv
// Self-checking testbench of the reset supervisor.
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_watchdog_test;
   import supervisor_pkg::*;
   localparam int RP = 30;
   localparam int DB = 10;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   supply_status_type supply_status = '0;
   logic trip_tolerance_select = TOL_TIGHT;
   timeout_select_type timeout_select = TSEL_LOW;
   logic manual_reset_n = 1'h1;
   logic strobe_en = 1'h0;
   logic watchdog_strobe_n;
   reset_out_type reset_out;
   int failures = 0;
   int checked = 0;
   int n;
   supervisor_reset_watchdog #(.WDT_SHORT(40), .WDT_MID(60), .WDT_LONG(80), .RESET_PERIOD(RP), .DEBOUNCE(DB)) i_dut (
      .clk_sys(clk_sys), .rst(rst), .supply_status(supply_status), .trip_tolerance_select(trip_tolerance_select),
      .timeout_select(timeout_select), .manual_reset_n(manual_reset_n), .watchdog_strobe_n(watchdog_strobe_n),
      .reset_out(reset_out));
   host_model #(.INTERVAL(20)) i_host (.clk_sys(clk_sys), .strobe_en(strobe_en), .watchdog_strobe_n(watchdog_strobe_n));
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic check_in(input string what, input int lo, input int hi, input int got);
      checked++;
      if (got < lo || got > hi) begin
         failures++;
         $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   // Counts cycles until the reset output reaches a level, giving up after max.
   task automatic wait_for(input logic val, input int max);
      n = 0;
      while (reset_out.reset !== val && n < max) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   task automatic final_report;
      $display("Checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(negedge clk_sys) begin
      if (!rst) begin
         check_in("reset pair complement", 1, 1, int'(reset_out.reset_n === ~reset_out.reset));
      end
   end
   task automatic power_up;
      repeat (8) @(negedge clk_sys);
      check_in("reset during power-on", 1, 1, int'(reset_out.reset === 1'h1));
      rst = 1'h0;
      wait_for(1'h0, RP + 20);
      check_in("power-up hold", RP - 2, RP + 6, n);
   endtask
   task automatic watchdog_all;
      timeout_select_type codes [4] = '{TSEL_LOW, TSEL_OPEN, TSEL_HIGH, timeout_select_type'(2'h3)};
      int limits [4] = '{40, 60, 80, 40};
      for (int i = 0; i < 4; i++) begin
         wait_for(1'h1, 200);
         check_in("watchdog timeout", limits[i] - 2, limits[i] + 4, n);
         timeout_select = codes[(i + 1) % 4];
         wait_for(1'h0, 200);
         check_in("watchdog reset hold", RP - 2, RP + 6, n);
      end
   endtask
   task automatic strobe_keep;
      strobe_en = 1'h1;
      wait_for(1'h1, 300);
      check_in("strobed watchdog stays quiet", 300, 300, n);
   endtask
   task automatic manual_press;
      manual_reset_n = 1'h0;
      repeat (5) @(negedge clk_sys);
      manual_reset_n = 1'h1;
      wait_for(1'h1, 20);
      check_in("short bounce ignored", 20, 20, n);
      manual_reset_n = 1'h0;
      wait_for(1'h1, DB + 10);
      check_in("manual assert delay", DB, DB + 4, n);
      repeat (10) @(negedge clk_sys);
      manual_reset_n = 1'h1;
      wait_for(1'h0, RP + DB + 20);
      check_in("manual release hold", RP - 2, RP + DB + 6, n);
   endtask
   task automatic supply_fail;
      trip_tolerance_select = TOL_LOOSE;
      supply_status.below_tight = 1'h1;
      wait_for(1'h1, 20);
      check_in("loose trip ignores tight", 20, 20, n);
      supply_status.below_loose = 1'h1;
      wait_for(1'h1, SUPPLY_FAIL_ASSERT_CYC);
      check_in("supply fail delay", 1, 5, n);
      wait_for(1'h0, 100);
      check_in("held while supply low", 100, 100, n);
      supply_status = '0;
      wait_for(1'h0, RP + 20);
      check_in("supply recovery hold", RP - 2, RP + 6, n);
      trip_tolerance_select = TOL_TIGHT;
      supply_status.below_tight = 1'h1;
      wait_for(1'h1, 20);
      check_in("tight trip asserts", 1, 5, n);
      supply_status = '0;
      wait_for(1'h0, RP + 20);
      check_in("tight recovery hold", RP - 2, RP + 6, n);
   endtask
   initial begin
      repeat (5000) @(negedge clk_sys);
      failures++;
      $display("BAD run did not finish in time");
      final_report();
   end
   initial begin
      power_up();
      watchdog_all();
      strobe_keep();
      manual_press();
      supply_fail();
      final_report();
   end
endmodule // supervisor_reset_watchdog_test
`default_nettype wire
